// *** tb/agp_pin_model.sv ***
// Purpose: outside world of one 8-bit port: pads, external drivers, floating pins
// Assumes: the bench never drives a pin while the device drives it
// Notes:   no pull resistor, so an undriven pin toggles every cycle
`timescale 1ns/10ps
module agp_pin_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] dev_out,
    input  wire logic [7:0] dev_oe,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_in
);
    logic [7:0] float_reg;
    // floating level changes every cycle so a stale value is never read
    initial float_reg = 8'h5A;
    always @(posedge ref_clk) begin
        float_reg <= ~float_reg;
    end
    // device drive wins, then the outside driver, else the floating level
    assign pin_in = (dev_oe & dev_out) | (~dev_oe & ext_en & ext_val)
                  | (~dev_oe & ~ext_en & float_reg);
endmodule // agp_pin_model

// *** tb/analog_shared_gpio_ports_bench.sv ***
// Purpose: self-checking bench for the three analog-shared ports
// Assumes: 25 MHz clock, registers reached by bank and offset
// Notes:   reads wait four edges so synchronised pin levels have landed
`timescale 1ns/10ps
module analog_shared_gpio_ports_bench;
    import agp_pkg::*;
    localparam logic [7:0] PB [3] = '{BANK_FG, BANK_FG, BANK_H};
    localparam logic [7:0] PD [3] = '{OFS_F_DIR, OFS_G_DIR, OFS_H_DIR};
    localparam logic [7:0] PR [3] = '{OFS_F_DATA, OFS_G_DATA, OFS_H_DATA};
    logic        ref_clk, resetn, reg_wr_en, result_format_sel;
    logic [7:0]  bank_selector, reg_addr, reg_wr_data, reg_rd_data;
    logic [7:0]  pin_in [3], pin_out [3], pin_oe [3], ext_en [3], ext_val [3];
    logic [15:0] analog_input_enable;
    logic [1:0]  conversion_clock_sel;
    logic        third_capture_input, second_serial_receive;
    logic        pwm_on, pwm_lvl, tx_oe, tx_lvl, dt_oe, dt_lvl;
    int          n_fail, cmp_count;

    agp_ports dut (.ref_clk(ref_clk), .resetn(resetn), .bank_selector(bank_selector),
        .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data), .first_port_pin_in(pin_in[0]),
        .first_port_pin_out(pin_out[0]), .first_port_pin_oe(pin_oe[0]),
        .second_port_pin_in(pin_in[1]), .second_port_pin_out(pin_out[1]),
        .second_port_pin_oe(pin_oe[1]), .third_port_pin_in(pin_in[2]),
        .third_port_pin_out(pin_out[2]), .third_port_pin_oe(pin_oe[2]),
        .analog_input_enable(analog_input_enable),
        .conversion_clock_sel(conversion_clock_sel), .result_format_sel(result_format_sel),
        .third_capture_input(third_capture_input), .third_pulse_width_on(pwm_on),
        .third_pulse_width_output(pwm_lvl), .serial_transmit_oe(tx_oe),
        .serial_transmit_level(tx_lvl), .serial_data_oe(dt_oe),
        .serial_data_level(dt_lvl), .second_serial_receive(second_serial_receive));

    // one pad model per port
    for (genvar g = 0; g < 3; g++) begin : g_pad
        agp_pin_model pads (.ref_clk(ref_clk), .dev_out(pin_out[g]), .dev_oe(pin_oe[g]),
            .ext_en(ext_en[g]), .ext_val(ext_val[g]), .pin_in(pin_in[g]));
    end

    // compare, count and report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic settle;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    // register write, one strobe cycle
    task automatic wr(input logic [7:0] bank, input logic [7:0] ofs, input logic [7:0] val);
        @(posedge ref_clk);
        bank_selector <= bank;
        reg_addr <= ofs;
        reg_wr_data <= val;
        reg_wr_en <= 1'b1;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] bank, input logic [7:0] ofs, input logic [7:0] exp,
                      input string what);
        @(posedge ref_clk);
        bank_selector <= bank;
        reg_addr <= ofs;
        settle();
        chk({8'h00, reg_rd_data}, {8'h00, exp}, what);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // reset state, with outside drive on analog pins
    task automatic t_reset;
        @(posedge ref_clk);
        ext_en[0] <= 8'hFF;
        ext_val[0] <= 8'hFF;
        settle();
        chk(analog_input_enable, ANALOG_RESET, "analog map after reset");
        for (int p = 0; p < 3; p++) begin
            chk({8'h00, pin_oe[p]}, 16'h0000, "drivers after reset");
            rd(PB[p], PD[p], DIR_RESET, "direction reset");
        end
        rd(BANK_FG, OFS_CFG, CFG_RESET, "config reset");
        rd(BANK_FG, OFS_F_DATA, 8'h00, "analog pins read");
        @(posedge ref_clk);
        ext_en[0] <= 8'h00;
    endtask
    // port configuration field against pin to channel mapping
    task automatic t_map;
        for (int p = 0; p < 3; p++) wr(PB[p], PR[p], 8'h00);
        for (int p = 0; p < 3; p++) wr(PB[p], PD[p], 8'h00);
        wr(BANK_FG, OFS_CFG, 8'h09);
        settle();
        chk(analog_input_enable, 16'h007F, "map field 9");
        chk({pin_oe[0], pin_oe[1]}, 16'hF8F0, "oe field 9");
        chk({8'h00, pin_oe[2]}, 16'h00FF, "third oe field 9");
        wr(BANK_FG, OFS_CFG, 8'h0D);
        settle();
        chk(analog_input_enable, 16'h0007, "map field D");
        chk({pin_oe[0], pin_oe[1]}, 16'hFFF1, "oe field D");
        wr(BANK_FG, OFS_CFG, 8'h03);
        settle();
        chk(analog_input_enable, 16'h1FFF, "map field 3");
        chk({pin_oe[0], pin_oe[2]}, 16'h00EF, "oe field 3");
        wr(BANK_FG, OFS_CFG, 8'hFF);
        settle();
        chk({13'h0, conversion_clock_sel, result_format_sel}, 16'h0007, "config fields");
        chk(analog_input_enable, 16'h0000, "all digital");
        rd(BANK_FG, OFS_CFG, 8'hEF, "config bit 4");
    endtask
    // direction, latch and pin read on every port
    task automatic t_dir;
        for (int p = 0; p < 3; p++) begin
            wr(PB[p], PD[p], 8'hFF);
            wr(PB[p], PR[p], 8'hA5);
            @(posedge ref_clk);
            ext_en[p] <= 8'hFF;
            ext_val[p] <= 8'h3C;
            settle();
            chk({8'h00, pin_oe[p]}, 16'h0000, "inputs undriven");
            rd(PB[p], PR[p], 8'h3C, "input pins read");
            @(posedge ref_clk);
            ext_en[p] <= 8'h0F;
            wr(PB[p], PD[p], 8'h0F);
            settle();
            chk({pin_oe[p], pin_out[p]}, 16'hF0A5, "outputs from latch");
            rd(PB[p], PR[p], 8'hAC, "mixed pins read");
            wr(PB[p], PD[p], 8'hFF);
            @(posedge ref_clk);
            ext_en[p] <= 8'h00;
        end
    endtask
    // peripheral functions on the second port upper nibble
    task automatic t_periph;
        @(posedge ref_clk);
        {pwm_on, pwm_lvl, tx_oe, tx_lvl} <= 4'b1110;
        ext_en[1] <= 8'h50;
        ext_val[1] <= 8'h50;
        settle();
        chk({14'h0, third_capture_input, second_serial_receive}, 16'h0003, "inputs high");
        chk({pin_oe[1], 6'h00, pin_out[1][7], pin_out[1][5]}, 16'hA001, "drive A");
        @(posedge ref_clk);
        {pwm_lvl, tx_lvl, dt_oe, dt_lvl} <= 4'b0110;
        ext_en[1] <= 8'h10;
        ext_val[1] <= 8'h00;
        settle();
        chk({14'h0, third_capture_input, second_serial_receive}, 16'h0000, "inputs low");
        chk({pin_oe[1], 5'h00, pin_out[1][7:5]}, 16'hE004, "drive B");
        @(posedge ref_clk);
        {pwm_on, tx_oe, dt_oe} <= 3'b000;
        ext_en[1] <= 8'h00;
    endtask
    // wrong bank and unmapped offsets leave registers alone
    task automatic t_bank;
        wr(8'h03, OFS_F_DIR, 8'h00);
        wr(BANK_H, OFS_CFG, 8'h00);
        rd(BANK_FG, OFS_F_DIR, 8'hFF, "wrong bank write");
        rd(BANK_FG, OFS_CFG, 8'hEF, "config kept");
        rd(BANK_FG, 8'h14, 8'h00, "unmapped read");
    endtask
    // second reset in mid-run brings analog inputs back
    task automatic t_rst_mid;
        @(posedge ref_clk);
        resetn <= 1'b0;
        ext_en[1] <= 8'hFF;
        ext_val[1] <= 8'h0F;
        ext_en[2] <= 8'hFF;
        ext_val[2] <= 8'hF0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        settle();
        chk(analog_input_enable, ANALOG_RESET, "analog after reset");
        rd(BANK_FG, OFS_G_DIR, DIR_RESET, "direction after reset");
        rd(BANK_FG, OFS_G_DATA, 8'h00, "second low nibble analog");
        rd(BANK_H, OFS_H_DATA, 8'h00, "third high nibble analog");
        @(posedge ref_clk);
        ext_en[1] <= 8'h00;
        ext_en[2] <= 8'h00;
    endtask

    // clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // hang guard
    initial begin
        #2ms;
        n_fail++;
        end_of_test();
    end
    // main sequence
    initial begin
        {resetn, reg_wr_en, pwm_on, pwm_lvl, tx_oe, tx_lvl, dt_oe, dt_lvl} = 8'h00;
        {bank_selector, reg_addr, reg_wr_data} = 24'h000000;
        ext_en = '{8'h00, 8'h00, 8'h00};
        ext_val = '{8'h00, 8'h00, 8'h00};
        n_fail = 0;
        cmp_count = 0;
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        t_reset();
        t_map();
        t_dir();
        t_periph();
        t_bank();
        t_rst_mid();
        end_of_test();
    end
endmodule // analog_shared_gpio_ports_bench

// *** verilog/agp_pin_bank.sv ***
// Purpose: one 8-bit port: direction, output latch, pin synchroniser, drivers
// Assumes: write strobes come from the register decoder on the same clock
// Notes:   an alternate function or analog selection overrides the latch path
`timescale 1ns/10ps
module agp_pin_bank
    import agp_pkg::*;
#(
    parameter logic [7:0] LATCH_RESET = 8'h00
) (
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire logic              dir_wr,
    input  wire logic              data_wr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic [DATA_W-1:0] analog_mask,
    input  wire logic [DATA_W-1:0] alt_oe,
    input  wire logic [DATA_W-1:0] alt_out,
    input  wire logic [DATA_W-1:0] pin_in,
    output logic      [DATA_W-1:0] dir_value,
    output logic      [DATA_W-1:0] latch_value,
    output logic      [DATA_W-1:0] pin_level,
    output logic      [DATA_W-1:0] pin_out,
    output logic      [DATA_W-1:0] pin_oe
);
    logic [DATA_W-1:0] dir_reg;
    logic [DATA_W-1:0] latch_reg;
    logic [DATA_W-1:0] sync1_reg;
    logic [DATA_W-1:0] sync2_reg;
    logic [DATA_W-1:0] out_reg;
    logic [DATA_W-1:0] oe_reg;
    logic [DATA_W-1:0] oe_next;
    logic [DATA_W-1:0] out_next;

    // driver enable: direction 0 or alternate enable drives, otherwise floats, analog always floats
    assign oe_next  = ~analog_mask & (alt_oe | ~dir_reg);
    assign out_next = (alt_oe & alt_out) | (~alt_oe & latch_reg);

    // direction and latch registers; latch loads regardless of direction
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dir_reg   <= DIR_RESET;
            latch_reg <= LATCH_RESET;
        end else begin
            if (dir_wr) begin
                dir_reg <= wr_data;
            end
            if (data_wr) begin
                latch_reg <= wr_data;
            end
        end
    end

    // two-stage pin synchroniser and registered drivers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= ZERO_BYTE;
            sync2_reg <= ZERO_BYTE;
            out_reg   <= ZERO_BYTE;
            oe_reg    <= ZERO_BYTE;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            out_reg   <= out_next;
            oe_reg    <= oe_next;
        end
    end

    assign dir_value   = dir_reg;
    assign latch_value = latch_reg;
    assign pin_level   = sync2_reg;
    assign pin_out     = out_reg;
    assign pin_oe      = oe_reg;
endmodule // agp_pin_bank

// *** verilog/agp_pkg.sv ***
// Purpose: shared constants for the analog-shared general-purpose port block
// Assumes: banked 8-bit register access from the core, one 25 MHz clock
// Notes:   channel and bit positions are fixed by the pin sharing of each port
package agp_pkg;
    localparam int          DATA_W        = 8;
    localparam int          CHAN_COUNT    = 16;
    // register banks and offsets inside a bank
    localparam logic [7:0]  BANK_FG       = 8'h05;
    localparam logic [7:0]  BANK_H        = 8'h08;
    localparam logic [7:0]  OFS_F_DIR     = 8'h10;
    localparam logic [7:0]  OFS_F_DATA    = 8'h11;
    localparam logic [7:0]  OFS_G_DIR     = 8'h12;
    localparam logic [7:0]  OFS_G_DATA    = 8'h13;
    localparam logic [7:0]  OFS_CFG       = 8'h15;
    localparam logic [7:0]  OFS_H_DIR     = 8'h10;
    localparam logic [7:0]  OFS_H_DATA    = 8'h11;
    // reset values
    localparam logic [7:0]  DIR_RESET     = 8'hFF;
    localparam logic [7:0]  F_DATA_RESET  = 8'h00;
    localparam logic [7:0]  G_DATA_RESET  = 8'h00;
    localparam logic [7:0]  H_DATA_RESET  = 8'h00;
    localparam logic [7:0]  CFG_RESET     = 8'h00;
    localparam logic [15:0] ANALOG_RESET  = 16'hFFFF;
    localparam logic [7:0]  ZERO_BYTE     = 8'h00;
    // converter configuration fields
    localparam logic [7:0]  CFG_IMPL_MASK = 8'hEF;
    localparam int          PCFG_HI       = 3;
    localparam int          PCFG_LO       = 0;
    localparam int          CLKSEL_HI     = 7;
    localparam int          CLKSEL_LO     = 6;
    localparam int          FORMAT_BIT    = 5;
    localparam int          UNIMPL_BIT    = 4;
    localparam logic [3:0]  PCFG_ALL_DIG  = 4'hE;
    // pin to channel mapping
    localparam int          F_CHAN_BASE   = 4;
    localparam int          G_CHAN_TOP    = 3;
    localparam int          G_ANALOG_PINS = 4;
    localparam int          H_CHAN_OFS    = 8;
    localparam int          H_ANALOG_LO   = 4;
    // peripheral pins of the second port
    localparam int          G_CAP_BIT     = 4;
    localparam int          G_PWM_BIT     = 5;
    localparam int          G_RX_BIT      = 6;
    localparam int          G_TX_BIT      = 7;
endpackage

// *** verilog/agp_ports.sv ***
// Purpose: three 8-bit general-purpose ports sharing pins with analog channels
// Assumes: core presents bank, offset and write strobe; one 25 MHz clock
// Notes:   read data is registered and follows the address one cycle later
`timescale 1ns/10ps
// Overview of operation
// - direction bit 1 makes the pin an input with its driver off unless a second port peripheral enables it.
// - direction bit 0 drives the pin from its output latch, except analog pins and enabled peripheral pins.
// - reading a port data register returns sampled pin levels, not the latch.
// - writing a port data register loads the latch whatever the direction.
// - first port bits 0 to 7 are analog channels 4 to 11.
// - any reset makes every first port pin an analog input.
// - second port bits 0 to 3 are channels 3, 2, 1, 0 respectively.
// - second port bit4 is third capture input, bit5 third pulse width output.
// - second port bits 6 and 7 carry the second serial transceiver signals.
// - any reset makes second port bits 3 to 0 analog inputs.
// - third port upper nibble is four analog channels, lower nibble digital.
// - any reset makes third port bits 7 to 4 analog inputs.
// - unimplemented register bits ignore writes and read as zero.
module agp_ports
    import agp_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    input  wire logic [7:0]            bank_selector,
    input  wire logic [7:0]            reg_addr,
    input  wire logic                  reg_wr_en,
    input  wire logic [DATA_W-1:0]     reg_wr_data,
    output logic      [DATA_W-1:0]     reg_rd_data,
    input  wire logic [DATA_W-1:0]     first_port_pin_in,
    output logic      [DATA_W-1:0]     first_port_pin_out,
    output logic      [DATA_W-1:0]     first_port_pin_oe,
    input  wire logic [DATA_W-1:0]     second_port_pin_in,
    output logic      [DATA_W-1:0]     second_port_pin_out,
    output logic      [DATA_W-1:0]     second_port_pin_oe,
    input  wire logic [DATA_W-1:0]     third_port_pin_in,
    output logic      [DATA_W-1:0]     third_port_pin_out,
    output logic      [DATA_W-1:0]     third_port_pin_oe,
    output logic      [CHAN_COUNT-1:0] analog_input_enable,
    output logic      [1:0]            conversion_clock_sel,
    output logic                       result_format_sel,
    output logic                       third_capture_input,
    input  wire logic                  third_pulse_width_on,
    input  wire logic                  third_pulse_width_output,
    input  wire logic                  serial_transmit_oe,
    input  wire logic                  serial_transmit_level,
    input  wire logic                  serial_data_oe,
    input  wire logic                  serial_data_level,
    output logic                       second_serial_receive
);
    logic [DATA_W-1:0]     cfg_reg;
    logic [CHAN_COUNT-1:0] analog_mask_reg;
    logic [DATA_W-1:0]     rd_data_reg;
    logic [DATA_W-1:0]     rd_next;
    logic [DATA_W-1:0]     f_an;
    logic [DATA_W-1:0]     g_an;
    logic [DATA_W-1:0]     h_an;
    logic [DATA_W-1:0]     g_alt_oe;
    logic [DATA_W-1:0]     g_alt_out;
    logic [DATA_W-1:0]     f_dir;
    logic [DATA_W-1:0]     f_latch;
    logic [DATA_W-1:0]     f_level;
    logic [DATA_W-1:0]     g_dir;
    logic [DATA_W-1:0]     g_latch;
    logic [DATA_W-1:0]     g_level;
    logic [DATA_W-1:0]     h_dir;
    logic [DATA_W-1:0]     h_latch;
    logic [DATA_W-1:0]     h_level;
    logic                  hit_f_dir;
    logic                  hit_f_data;
    logic                  hit_g_dir;
    logic                  hit_g_data;
    logic                  hit_cfg;
    logic                  hit_h_dir;
    logic                  hit_h_data;

    // address match of one banked register
    function automatic logic reg_hit(input logic [7:0] bank, input logic [7:0] ofs,
                                     input logic [7:0] want_bank,
                                     input logic [7:0] want_ofs);
        return (bank == want_bank) && (ofs == want_ofs);
    endfunction

    // channels left analog by a port configuration field value
    function automatic logic [CHAN_COUNT-1:0] chan_analog(input logic [3:0] pcfg);
        logic [CHAN_COUNT-1:0] m;
        m = '0;
        for (int n = 0; n < CHAN_COUNT; n++) begin
            if ((pcfg < PCFG_ALL_DIG) && (n < (CHAN_COUNT - int'(pcfg)))) begin
                m[n] = 1'b1;
            end
        end
        return m;
    endfunction

    // register decode; first and second ports share bank 5 with the configuration register, third port in bank 8
    assign hit_f_dir  = reg_hit(bank_selector, reg_addr, BANK_FG, OFS_F_DIR);
    assign hit_f_data = reg_hit(bank_selector, reg_addr, BANK_FG, OFS_F_DATA);
    assign hit_g_dir  = reg_hit(bank_selector, reg_addr, BANK_FG, OFS_G_DIR);
    assign hit_g_data = reg_hit(bank_selector, reg_addr, BANK_FG, OFS_G_DATA);
    assign hit_cfg    = reg_hit(bank_selector, reg_addr, BANK_FG, OFS_CFG);
    assign hit_h_dir  = reg_hit(bank_selector, reg_addr, BANK_H, OFS_H_DIR);
    assign hit_h_data = reg_hit(bank_selector, reg_addr, BANK_H, OFS_H_DATA);

    // per-pin analog selection from the channel map
    genvar i;
    generate
        for (i = 0; i < DATA_W; i++) begin : g_map
            assign f_an[i] = analog_mask_reg[F_CHAN_BASE + i];
            if (i < G_ANALOG_PINS) begin : g_low
                assign g_an[i] = analog_mask_reg[G_CHAN_TOP - i];
            end else begin : g_high
                assign g_an[i] = 1'b0;
            end
            if (i >= H_ANALOG_LO) begin : h_high
                assign h_an[i] = analog_mask_reg[H_CHAN_OFS + i];
            end else begin : h_low
                assign h_an[i] = 1'b0;
            end
        end
    endgenerate

    // second port peripheral drivers: pulse width output, serial data, serial transmit
    assign g_alt_oe  = {serial_transmit_oe, serial_data_oe, third_pulse_width_on,
                        5'h00};
    assign g_alt_out = {serial_transmit_level, serial_data_level,
                        third_pulse_width_output, 5'h00};

    // read mux: pins as sampled, analog pins read zero, unmapped read zero
    always_comb begin
        rd_next = ZERO_BYTE;
        if (hit_f_dir) begin
            rd_next = f_dir;
        end else if (hit_f_data) begin
            rd_next = f_level & ~f_an;
        end else if (hit_g_dir) begin
            rd_next = g_dir;
        end else if (hit_g_data) begin
            rd_next = g_level & ~g_an;
        end else if (hit_cfg) begin
            rd_next = cfg_reg & CFG_IMPL_MASK;
        end else if (hit_h_dir) begin
            rd_next = h_dir;
        end else if (hit_h_data) begin
            rd_next = h_level & ~h_an;
        end
    end

    // configuration register, registered channel map and read data
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_reg         <= CFG_RESET;
            analog_mask_reg <= ANALOG_RESET;
            rd_data_reg     <= ZERO_BYTE;
        end else begin
            if (reg_wr_en && hit_cfg) begin
                cfg_reg <= reg_wr_data & CFG_IMPL_MASK;
            end
            analog_mask_reg <= chan_analog(cfg_reg[PCFG_HI:PCFG_LO]);
            rd_data_reg     <= rd_next;
        end
    end

    agp_pin_bank #(.LATCH_RESET(F_DATA_RESET)) u_first (
        .ref_clk     (ref_clk),
        .resetn      (resetn),
        .dir_wr      (reg_wr_en && hit_f_dir),
        .data_wr     (reg_wr_en && hit_f_data),
        .wr_data     (reg_wr_data),
        .analog_mask (f_an),
        .alt_oe      (ZERO_BYTE),
        .alt_out     (ZERO_BYTE),
        .pin_in      (first_port_pin_in),
        .dir_value   (f_dir),
        .latch_value (f_latch),
        .pin_level   (f_level),
        .pin_out     (first_port_pin_out),
        .pin_oe      (first_port_pin_oe)
    );

    agp_pin_bank #(.LATCH_RESET(G_DATA_RESET)) u_second (
        .ref_clk     (ref_clk),
        .resetn      (resetn),
        .dir_wr      (reg_wr_en && hit_g_dir),
        .data_wr     (reg_wr_en && hit_g_data),
        .wr_data     (reg_wr_data),
        .analog_mask (g_an),
        .alt_oe      (g_alt_oe),
        .alt_out     (g_alt_out),
        .pin_in      (second_port_pin_in),
        .dir_value   (g_dir),
        .latch_value (g_latch),
        .pin_level   (g_level),
        .pin_out     (second_port_pin_out),
        .pin_oe      (second_port_pin_oe)
    );

    agp_pin_bank #(.LATCH_RESET(H_DATA_RESET)) u_third (
        .ref_clk     (ref_clk),
        .resetn      (resetn),
        .dir_wr      (reg_wr_en && hit_h_dir),
        .data_wr     (reg_wr_en && hit_h_data),
        .wr_data     (reg_wr_data),
        .analog_mask (h_an),
        .alt_oe      (ZERO_BYTE),
        .alt_out     (ZERO_BYTE),
        .pin_in      (third_port_pin_in),
        .dir_value   (h_dir),
        .latch_value (h_latch),
        .pin_level   (h_level),
        .pin_out     (third_port_pin_out),
        .pin_oe      (third_port_pin_oe)
    );

    // outputs, all taken from flip-flops
    assign reg_rd_data           = rd_data_reg;
    assign analog_input_enable   = analog_mask_reg;
    assign conversion_clock_sel  = cfg_reg[CLKSEL_HI:CLKSEL_LO];
    assign result_format_sel     = cfg_reg[FORMAT_BIT];
    assign third_capture_input   = g_level[G_CAP_BIT];
    assign second_serial_receive = g_level[G_RX_BIT];

    // checks
    analog_pin_float_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        $past(f_an) != ZERO_BYTE |-> (first_port_pin_oe & $past(f_an)) == ZERO_BYTE)
        else $error("analog first port pin is driven");
    input_dir_float_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (first_port_pin_oe & $past(f_dir)) == ZERO_BYTE)
        else $error("input pin of first port is driven");
    output_from_latch_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        ($past(h_dir) == ZERO_BYTE) && ($past(h_an) == ZERO_BYTE)
        |-> (third_port_pin_oe == DIR_RESET) && (third_port_pin_out == $past(h_latch)))
        else $error("third port output does not follow its latch");
    latch_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        reg_wr_en && hit_g_data |=> g_latch == $past(reg_wr_data))
        else $error("second port latch not loaded by write");
    first_latch_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        reg_wr_en && hit_f_data |=> f_latch == $past(reg_wr_data))
        else $error("first port latch not loaded by write");
    read_pins_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        $past(hit_f_data) && ($past(f_an) == ZERO_BYTE) |-> reg_rd_data == $past(f_level))
        else $error("first port read does not return pin levels");
    reset_analog_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        $past(!resetn) |-> (analog_mask_reg == ANALOG_RESET) && (first_port_pin_oe == ZERO_BYTE))
        else $error("pins not analog after reset");
    unimpl_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        $past(hit_cfg) |-> !reg_rd_data[UNIMPL_BIT])
        else $error("unimplemented configuration bit reads one");
    pwm_drive_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        $past(third_pulse_width_on) |-> second_port_pin_oe[G_PWM_BIT]
        && (second_port_pin_out[G_PWM_BIT] == $past(third_pulse_width_output)))
        else $error("pulse width output not driven on its pin");
    tx_drive_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        $past(serial_transmit_oe) |-> second_port_pin_oe[G_TX_BIT]
        && (second_port_pin_out[G_TX_BIT] == $past(serial_transmit_level)))
        else $error("serial transmit not driven on its pin");
    high_nibble_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        $past(analog_mask_reg == ANALOG_RESET) |-> third_port_pin_oe[DATA_W-1:H_ANALOG_LO] == '0)
        else $error("third port high nibble driven while analog");
endmodule // agp_ports
